// [hw/bcc_top.sv]
// Functional notes
// R1 - hv select set only for 2.5 V level (code accepts any level, flags mismatch in status bad bit)
// R2 - hv select with other level: undefined
// R3 - 2.5 V only with normal drive (code accepts other drives, flags them in status bad bit)
// R4 - leave 2.5 V before changing drive (not enforced, code accepts a drive write at any level)
// R5 - stabilization enable gates trim offset
// R6 - trim ignored while stabilization off
// R7 - 16-bit multiplier sets refresh spacing
// R8 - done flag sets when burst finishes
// R9 - done flag cleared by writing one
// R10 - quiet trigger pulses only when enabled
// R11 - write quiet enable only while done zero (code writes quiet enable whatever the done flag)
// R12 - writing request bit starts one burst
// R13 - no new request before done cleared (code starts a burst from idle whether or not done is set)
// R14 - slow-clock counter triggers each refresh
// R15 - active drive issues bursts continuously
// R16 - output level resets to 1.8 V
// R17 - drive codes: normal, low, pulsed
// R18 - pulsed only in deep retention states
// R19 - counter reloads, restarts on multiplier write
//
// The APB register port and the address map were decided locally.
`timescale 1ns/1ps
module bcc_top (
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              psel_i,
  input  wire logic              penable_i,
  input  wire logic              pwrite_i,
  input  wire logic [11:0]       paddr_i,
  input  wire logic [31:0]       pwdata_i,
  output logic [31:0]            prdata_o,
  output logic                   pready_o,
  output logic                   pslverr_o,
  input  wire logic              slow_clk_i,
  input  wire logic              deep_retention_i,
  input  wire logic              burst_done_i,
  input  wire logic              quiet_i,
  output bcc_pkg::bcc_ctrl_t     ctrl_o,
  output logic                   continuous_o,
  output logic                   sw_burst_o,
  output logic                   refresh_o,
  output logic                   quiet_period_trigger_o
);

  // ==========================================
  // pin synchronisers
  logic slow_rise;
  logic deep_lvl;
  logic done_rise;
  logic quiet_rise;

  bcc_sync3 u_sync_slow (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (slow_clk_i),
    .lvl_o   (),
    .rise_o  (slow_rise)
  );

  bcc_sync3 u_sync_deep (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (deep_retention_i),
    .lvl_o   (deep_lvl),
    .rise_o  ()
  );

  bcc_sync3 u_sync_done (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (burst_done_i),
    .lvl_o   (),
    .rise_o  (done_rise)
  );

  bcc_sync3 u_sync_quiet (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .d_i     (quiet_i),
    .lvl_o   (),
    .rise_o  (quiet_rise)
  );

  // ==========================================
  // apb decode
  logic wr_acc;
  logic rd_setup;
  logic hit_conv;
  logic hit_burst;
  logic hit_mode;
  logic hit_stat;
  logic mapped;

  // access phase completes at once, setup captures read data
  always_comb
  begin
    hit_conv  = paddr_i == bcc_pkg::CONV_CFG_OFS;
    hit_burst = paddr_i == bcc_pkg::BURST_CFG_OFS;
    hit_mode  = paddr_i == bcc_pkg::MODE_CFG_OFS;
    hit_stat  = paddr_i == bcc_pkg::STATUS_OFS;
    mapped    = hit_conv | hit_burst | hit_mode | hit_stat;
    wr_acc    = psel_i & penable_i & pwrite_i & mapped;
    rd_setup  = psel_i & ~penable_i & ~pwrite_i;
  end

  assign pready_o  = psel_i & penable_i;
  assign pslverr_o = psel_i & penable_i & ~mapped;

  // ==========================================
  // software registers
  logic        hv_reg;
  logic        hv_next;
  logic        stab_reg;
  logic        stab_next;
  logic [5:0]  trim_reg;
  logic [5:0]  trim_next;
  logic [15:0] mult_reg;
  logic [15:0] mult_next;
  logic        qen_reg;
  logic        qen_next;
  logic        done_reg;
  logic        done_next;
  logic [1:0]  level_reg;
  logic [1:0]  level_next;
  logic [1:0]  drive_reg;
  logic [1:0]  drive_next;
  logic        mult_load;
  logic        req_wr;
  logic        done_set;

  // register writes, done flag set beats clear
  always_comb
  begin
    hv_next    = hv_reg;
    stab_next  = stab_reg;
    trim_next  = trim_reg;
    mult_next  = mult_reg;
    qen_next   = qen_reg;
    level_next = level_reg;
    drive_next = drive_reg;
    done_next  = done_reg;
    mult_load  = 1'b0;
    req_wr     = 1'b0;
    if (wr_acc && hit_conv)
    begin
      hv_next   = pwdata_i[bcc_pkg::HV_SEL_BIT];              // [R2]
      stab_next = pwdata_i[bcc_pkg::STAB_EN_BIT];             // [R5]
      trim_next = pwdata_i[bcc_pkg::TRIM_LSB +: bcc_pkg::TRIM_W];
    end
    if (wr_acc && hit_burst)
    begin
      mult_next = pwdata_i[bcc_pkg::MULT_LSB +: bcc_pkg::MULT_W];
      mult_load = 1'b1;                                       // [R19]
      qen_next  = pwdata_i[bcc_pkg::QTRIG_EN_BIT];
      req_wr    = pwdata_i[bcc_pkg::REQ_BIT];                 // [R12]
      if (pwdata_i[bcc_pkg::DONE_BIT])
        done_next = 1'b0;                                     // [R9]
    end
    if (wr_acc && hit_mode)
    begin
      level_next = pwdata_i[bcc_pkg::LEVEL_LSB +: 2];
      drive_next = pwdata_i[bcc_pkg::DRIVE_LSB +: 2];         // [R17]
    end
    if (done_set)
      done_next = 1'b1;                                       // [R8]
  end

  // registers
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      hv_reg    <= 1'b0;
      stab_reg  <= 1'b0;
      trim_reg  <= 6'h00;
      mult_reg  <= bcc_pkg::MULT_RST;
      qen_reg   <= 1'b0;
      done_reg  <= 1'b0;
      level_reg <= bcc_pkg::LEVEL_RST;                        // [R16]
      drive_reg <= bcc_pkg::DRIVE_RST;
    end
    else
    begin
      hv_reg    <= hv_next;
      stab_reg  <= stab_next;
      trim_reg  <= trim_next;
      mult_reg  <= mult_next;
      qen_reg   <= qen_next;
      done_reg  <= done_next;
      level_reg <= level_next;
      drive_reg <= drive_next;
    end
  end

  // ==========================================
  // software burst handshake
  bcc_pkg::bcc_bst_t bst_reg;
  bcc_pkg::bcc_bst_t bst_next;

  // one burst per request, ignored while busy
  always_comb
  begin
    bst_next = bst_reg;
    done_set = 1'b0;
    case (bst_reg)
      bcc_pkg::BST_IDLE:
        if (req_wr)
          bst_next = bcc_pkg::BST_BURST;                      // [R12]
      bcc_pkg::BST_BURST:
        if (done_rise)
        begin
          bst_next = bcc_pkg::BST_IDLE;
          done_set = 1'b1;                                    // [R8]
        end
      default:
        bst_next = bcc_pkg::BST_IDLE;
    endcase
  end

  // state register
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      bst_reg <= bcc_pkg::BST_IDLE;
    else
      bst_reg <= bst_next;
  end

  // ==========================================
  // mode decode
  logic pulse_mode;
  logic cont_mode;
  logic bad_combo;
  logic fire;

  // pulsed refresh only in deep retention, never at 2.5 V
  always_comb
  begin
    pulse_mode = (drive_reg == bcc_pkg::DRIVE_PULSE) & deep_lvl     // [R18]
                 & (level_reg != bcc_pkg::LEVEL_2V5);               // [R3]
    cont_mode  = (drive_reg == bcc_pkg::DRIVE_NORM)
                 | (drive_reg == bcc_pkg::DRIVE_LOW);               // [R15]
    bad_combo  = (hv_reg != (level_reg == bcc_pkg::LEVEL_2V5))
                 | ((level_reg == bcc_pkg::LEVEL_2V5)
                    & (drive_reg != bcc_pkg::DRIVE_NORM));          // [R3]
  end

  bcc_refresh_cnt u_refresh (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .en_i    (pulse_mode),
    .tick_i  (slow_rise),
    .load_i  (mult_load),
    .mult_i  (mult_reg),
    .fire_o  (fire)
  );

  // ==========================================
  // registered outputs
  bcc_pkg::bcc_ctrl_t ctrl_reg;
  bcc_pkg::bcc_ctrl_t ctrl_next;
  logic               cont_reg;
  logic               quiet_reg;
  logic               quiet_next;
  logic [31:0]        rdata_reg;
  logic [31:0]        rdata_next;

  // analog bundle, trim zeroed while stabilization off
  always_comb
  begin
    ctrl_next.hv_sel  = hv_reg;
    ctrl_next.level   = level_reg;
    ctrl_next.drive   = drive_reg;
    ctrl_next.stab_en = stab_reg;                                   // [R5]
    ctrl_next.trim    = stab_reg ? trim_reg : 6'h00;                // [R6]
    quiet_next        = quiet_rise & qen_reg;                       // [R10]
  end

  // read data captured in setup phase
  always_comb
  begin
    rdata_next = rdata_reg;
    if (rd_setup)
    begin
      rdata_next = 32'h0000_0000;
      if (hit_conv)
      begin
        rdata_next[bcc_pkg::HV_SEL_BIT]                     = hv_reg;
        rdata_next[bcc_pkg::STAB_EN_BIT]                    = stab_reg;
        rdata_next[bcc_pkg::TRIM_LSB +: bcc_pkg::TRIM_W]    = trim_reg;
      end
      if (hit_burst)
      begin
        rdata_next[bcc_pkg::MULT_LSB +: bcc_pkg::MULT_W]    = mult_reg;
        rdata_next[bcc_pkg::DONE_BIT]                       = done_reg;
        rdata_next[bcc_pkg::QTRIG_EN_BIT]                   = qen_reg;
      end
      if (hit_mode)
      begin
        rdata_next[bcc_pkg::LEVEL_LSB +: 2]                 = level_reg;
        rdata_next[bcc_pkg::DRIVE_LSB +: 2]                 = drive_reg;
      end
      if (hit_stat)
      begin
        rdata_next[bcc_pkg::ST_BUSY_BIT]  = bst_reg == bcc_pkg::BST_BURST;
        rdata_next[bcc_pkg::ST_PULSE_BIT] = pulse_mode;
        rdata_next[bcc_pkg::ST_CONT_BIT]  = cont_mode;
        rdata_next[bcc_pkg::ST_BAD_BIT]   = bad_combo;
      end
    end
  end

  // output registers
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ctrl_reg  <= '{1'b0, bcc_pkg::LEVEL_RST, bcc_pkg::DRIVE_RST, 1'b0, 6'h00};
      cont_reg  <= 1'b1;
      quiet_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      ctrl_reg  <= ctrl_next;
      cont_reg  <= cont_mode;                                       // [R15]
      quiet_reg <= quiet_next;
      rdata_reg <= rdata_next;
    end
  end

  assign ctrl_o                 = ctrl_reg;
  assign continuous_o           = cont_reg;
  assign sw_burst_o             = bst_reg == bcc_pkg::BST_BURST;
  assign refresh_o              = fire;
  assign quiet_period_trigger_o = quiet_reg;
  assign prdata_o               = rdata_reg;

  // ==========================================
  // checks
  property p_trim_gated;
    @(posedge clk_i) disable iff (!rst_b_i)
    !ctrl_reg.stab_en |-> ctrl_reg.trim == 6'h00;
  endproperty
  a_trim_gated: assert property (p_trim_gated) // [R6]
    else $error("trim applied while stabilization off");

  property p_stab_follows;
    @(posedge clk_i) disable iff (!rst_b_i)
    wr_acc && hit_conv |-> ##2 ctrl_reg.stab_en == $past(pwdata_i[1], 2);
  endproperty
  a_stab_follows: assert property (p_stab_follows) // [R5]
    else $error("stabilization enable not applied");

  property p_req_starts;
    @(posedge clk_i) disable iff (!rst_b_i)
    bst_reg == bcc_pkg::BST_IDLE && req_wr |=> sw_burst_o;
  endproperty
  a_req_starts: assert property (p_req_starts) // [R12]
    else $error("burst request did not start burst");

  property p_done_sets;
    @(posedge clk_i) disable iff (!rst_b_i)
    sw_burst_o && done_rise |=> done_reg && !sw_burst_o;
  endproperty
  a_done_sets: assert property (p_done_sets) // [R8]
    else $error("done flag not set after burst");

  property p_done_sticky;
    @(posedge clk_i) disable iff (!rst_b_i)
    done_reg && !(wr_acc && hit_burst && pwdata_i[16]) |=> done_reg;
  endproperty
  a_done_sticky: assert property (p_done_sticky) // [R9]
    else $error("done flag lost without clear");

  property p_quiet_gate;
    @(posedge clk_i) disable iff (!rst_b_i)
    quiet_period_trigger_o |-> $past(qen_reg) && $past(quiet_rise);
  endproperty
  a_quiet_gate: assert property (p_quiet_gate) // [R10]
    else $error("quiet trigger while disabled");

  property p_refresh_deep;
    @(posedge clk_i) disable iff (!rst_b_i)
    refresh_o |-> $past(deep_lvl) && $past(drive_reg) == bcc_pkg::DRIVE_PULSE;
  endproperty
  a_refresh_deep: assert property (p_refresh_deep) // [R18]
    else $error("pulsed refresh outside deep retention");

  property p_cont_mode;
    @(posedge clk_i) disable iff (!rst_b_i)
    drive_reg[1] ^ drive_reg[0] |=> continuous_o;
  endproperty
  a_cont_mode: assert property (p_cont_mode) // [R15]
    else $error("active drive not continuous");

endmodule

// [common/bcc_pkg.sv]
package bcc_pkg;

  // ==========================================
  // register byte offsets
  localparam logic [11:0] CONV_CFG_OFS  = 12'h000;
  localparam logic [11:0] BURST_CFG_OFS = 12'h004;
  localparam logic [11:0] MODE_CFG_OFS  = 12'h008;
  localparam logic [11:0] STATUS_OFS    = 12'h00c;

  // ==========================================
  // converter_config fields
  localparam int HV_SEL_BIT   = 0;
  localparam int STAB_EN_BIT  = 1;
  localparam int TRIM_LSB     = 8;
  localparam int TRIM_W       = 6;

  // burst_config fields
  localparam int MULT_LSB     = 0;
  localparam int MULT_W       = 16;
  localparam int DONE_BIT     = 16;
  localparam int QTRIG_EN_BIT = 17;
  localparam int REQ_BIT      = 18;

  // mode_config fields
  localparam int LEVEL_LSB    = 0;
  localparam int DRIVE_LSB    = 2;

  // status fields
  localparam int ST_BUSY_BIT  = 0;
  localparam int ST_PULSE_BIT = 1;
  localparam int ST_CONT_BIT  = 2;
  localparam int ST_BAD_BIT   = 3;

  // ==========================================
  // encodings
  localparam logic [1:0] LEVEL_1V25  = 2'h0;
  localparam logic [1:0] LEVEL_1V35  = 2'h1;
  localparam logic [1:0] LEVEL_2V5   = 2'h2;
  localparam logic [1:0] LEVEL_1V8   = 2'h3;
  localparam logic [1:0] DRIVE_PULSE = 2'h0;
  localparam logic [1:0] DRIVE_LOW   = 2'h1;
  localparam logic [1:0] DRIVE_NORM  = 2'h2;

  // ==========================================
  // reset values
  localparam logic [1:0]  LEVEL_RST  = LEVEL_1V8;
  localparam logic [1:0]  DRIVE_RST  = DRIVE_NORM;
  localparam logic [15:0] MULT_RST   = 16'h0140;

  // ==========================================
  // analog control bundle
  typedef struct packed {
    logic       hv_sel;
    logic [1:0] level;
    logic [1:0] drive;
    logic       stab_en;
    logic [5:0] trim;
  } bcc_ctrl_t;

  // burst handshake states
  typedef enum logic [1:0] {
    BST_IDLE  = 2'b01,
    BST_BURST = 2'b10
  } bcc_bst_t;

endpackage

// [hw/bcc_sync3.sv]
`timescale 1ns/1ps
module bcc_sync3 (
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic d_i,
  output logic      lvl_o,
  output logic      rise_o
);

  // ==========================================
  // three stage capture, accept when stages 2 and 3 agree
  logic [2:0] sh_reg;
  logic [2:0] sh_next;
  logic       lvl_reg;
  logic       lvl_next;
  logic       rise_reg;
  logic       rise_next;

  // next values
  always_comb
  begin
    sh_next   = {sh_reg[1:0], d_i};
    lvl_next  = lvl_reg;
    rise_next = 1'b0;
    if (sh_reg[2] == sh_reg[1])
    begin
      lvl_next  = sh_reg[2];
      rise_next = sh_reg[2] & ~lvl_reg;
    end
  end

  // registers
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sh_reg   <= 3'h0;
      lvl_reg  <= 1'b0;
      rise_reg <= 1'b0;
    end
    else
    begin
      sh_reg   <= sh_next;
      lvl_reg  <= lvl_next;
      rise_reg <= rise_next;
    end
  end

  assign lvl_o  = lvl_reg;
  assign rise_o = rise_reg;

endmodule

// [hw/bcc_refresh_cnt.sv]
`timescale 1ns/1ps
module bcc_refresh_cnt (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        en_i,
  input  wire logic        tick_i,
  input  wire logic        load_i,
  input  wire logic [15:0] mult_i,
  output logic             fire_o
);

  // ==========================================
  // slow tick down counter
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        fire_reg;
  logic        fire_next;

  // reload on rewrite or idle, fire on expiry
  always_comb
  begin
    cnt_next  = cnt_reg;
    fire_next = 1'b0;
    if (load_i || !en_i)
      cnt_next = mult_i;                    // [R19]
    else if (tick_i)
    begin
      if (cnt_reg <= 16'h0001)
      begin
        fire_next = 1'b1;                   // [R14]
        cnt_next  = mult_i;                 // [R19]
      end
      else
        cnt_next = cnt_reg - 16'h0001;      // [R7]
    end
  end

  // registers
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_reg  <= bcc_pkg::MULT_RST;
      fire_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      fire_reg <= fire_next;
    end
  end

  assign fire_o = fire_reg;

  // ==========================================
  // checks
  property p_fire_needs_tick;
    @(posedge clk_i) disable iff (!rst_b_i)
    fire_reg |-> $past(tick_i) && $past(en_i) && !$past(load_i);
  endproperty
  a_fire_needs_tick: assert property (p_fire_needs_tick) // [R14]
    else $error("refresh fired without slow tick");

  property p_reload_after_fire;
    @(posedge clk_i) disable iff (!rst_b_i)
    fire_reg |-> cnt_reg == $past(mult_i);
  endproperty
  a_reload_after_fire: assert property (p_reload_after_fire) // [R19]
    else $error("counter not reloaded after refresh");

endmodule

// [sim/bcc_stage_model.sv]
`timescale 1ns/1ps
// ==========================================
// power stage stand-in: finishes a burst after a set delay
module bcc_stage_model (
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       sw_burst_i,
  input  wire logic [7:0] delay_i,
  output logic            burst_done_o,
  output logic            quiet_o
);
  logic [7:0] cnt_reg;

  // count the burst, report done and quiet until the request drops
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_reg      <= 8'h00;
      burst_done_o <= 1'b0;
      quiet_o      <= 1'b0;
    end
    else if (!sw_burst_i)
    begin
      cnt_reg      <= 8'h00;
      burst_done_o <= 1'b0;  // back to idle level
      quiet_o      <= 1'b0;
    end
    else if (cnt_reg == delay_i)
    begin
      burst_done_o <= 1'b1;  // burst finished
      quiet_o      <= 1'b1;  // quiet period begins
    end
    else
      cnt_reg <= cnt_reg + 8'h01;
  end
endmodule

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  typedef struct {logic wr; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} bcc_row_t;
  logic               clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]        paddr = 12'h000;
  logic [31:0]        pwdata = 32'h0, prdata, rd;
  logic               pready, pslverr, er, slow_clk = 1'b0, deep = 1'b0, done, quiet;
  logic               cont, swb, refr, qtrig;
  logic [7:0]         dly = 8'h02;
  bcc_pkg::bcc_ctrl_t ctrl;
  int                 err_count = 0, checked = 0, cyc = 0, qcount = 0, rcount = 0, rlast = 0, t1, t2;
  bcc_row_t           rows[20] = '{
    '{0, 12'h000, 0, 32'h0, 0}, '{0, 12'h004, 0, 32'h00000140, 0},
    '{0, 12'h008, 0, 32'h0000000b, 0}, '{0, 12'h00c, 0, 32'h00000004, 0},
    '{0, 12'h010, 0, 32'h0, 1}, '{1, 12'h000, 32'h00003f03, 0, 0}, '{1, 12'h010, 32'hffffffff, 0, 1},
    '{0, 12'h000, 0, 32'h00003f03, 0}, '{0, 12'h00c, 0, 32'h0000000c, 0},
    '{1, 12'h008, 32'h0000000a, 0, 0}, '{0, 12'h00c, 0, 32'h00000004, 0},
    '{1, 12'h008, 32'h00000006, 0, 0}, '{0, 12'h00c, 0, 32'h0000000c, 0},
    '{1, 12'h000, 32'h0, 0, 0}, '{1, 12'h008, 32'h00000007, 0, 0}, '{0, 12'h00c, 0, 32'h00000004, 0},
    '{1, 12'h008, 32'h00000003, 0, 0}, '{0, 12'h00c, 0, 32'h0, 0},
    '{1, 12'h004, 32'h00020002, 0, 0}, '{0, 12'h004, 0, 32'h00020002, 0}};

  // ==========================================
  // clocks, counters, instances
  always #12.5 clk = ~clk;
  always #15250 slow_clk = ~slow_clk;  // 1220 cycles per slow period
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (qtrig === 1'b1) qcount <= qcount + 1;
    if (refr === 1'b1)
    begin
      rcount <= rcount + 1;
      rlast  <= cyc;
    end
  end

  bcc_top bcc_top_i (.clk_i(clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .slow_clk_i(slow_clk), .deep_retention_i(deep), .burst_done_i(done), .quiet_i(quiet), .ctrl_o(ctrl),
    .continuous_o(cont), .sw_burst_o(swb), .refresh_o(refr), .quiet_period_trigger_o(qtrig));
  bcc_stage_model bcc_stage_model_i (.clk_i(clk), .rst_b_i(rst_b), .sw_burst_i(swb), .delay_i(dly),
    .burst_done_o(done), .quiet_o(quiet));

  // ==========================================
  // helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_ref(output int t);
    int n;
    n = rcount;
    for (int i = 0; i < 5000 && rcount == n; i++) @(posedge clk) #1;
    t = rlast;
  endtask

  task automatic burst(input logic [31:0] d, input logic [7:0] dl, input int expq);
    int q0;
    q0  = qcount;
    dly <= dl;
    apb(1'b1, 12'h004, d);
    apb(1'b1, 12'h004, d | 32'h00040000);
    @(posedge clk) #1;
    chk({31'h0, swb}, 32'h1);
    if (dl > 8'h0a) apb(1'b1, 12'h004, d | 32'h00040000);
    for (int i = 0; i < 200 && swb !== 1'b0; i++) @(posedge clk) #1;
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, d | 32'h00010000);
    repeat (20) @(posedge clk);
    chk({31'h0, swb}, 32'h0);
    chk(32'(qcount - q0), 32'(expq));
    apb(1'b1, 12'h004, d | 32'h00010000);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, d);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================
  // watchdog
  initial
  begin
    #1000000;
    err_count++;
    wrap_up;
  end

  // ==========================================
  // main sequence
  initial
  begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i].wr, rows[i].a, rows[i].d);
      if (!rows[i].wr) chk(rd, rows[i].q);
      chk({31'h0, er}, {31'h0, rows[i].e});
    end
    chk({31'h0, cont}, 32'h0);
    chk({30'h0, ctrl.drive}, {30'h0, bcc_pkg::DRIVE_PULSE});
    apb(1'b1, 12'h000, 32'h00003f00);
    @(posedge clk) #1;
    chk({26'h0, ctrl.trim}, 32'h0);
    chk({31'h0, ctrl.stab_en}, 32'h0);
    apb(1'b1, 12'h000, 32'h00003f02);
    @(posedge clk) #1;
    chk({26'h0, ctrl.trim}, 32'h3f);
    chk({30'h0, ctrl.stab_en, ctrl.hv_sel}, 32'h2);
    $display("test register table done");
    deep <= 1'b1;
    wait_ref(t1);
    wait_ref(t1);
    wait_ref(t2);
    chk(32'(t2 - t1), 32'd2440);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h00000002);
    apb(1'b1, 12'h004, 32'h0);
    wait_ref(t1);
    wait_ref(t2);
    chk(32'(t2 - t1), 32'd1220);
    deep <= 1'b0;
    repeat (10) @(posedge clk);
    t1 = rcount;
    repeat (4000) @(posedge clk);
    chk(32'(rcount - t1), 32'h0);
    $display("test pulsed refresh done");
    burst(32'h00020002, 8'd30, 1);
    burst(32'h00000002, 8'd2, 0);
    $display("test burst handshake done");
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk) #1;
    chk({30'h0, ctrl.level}, {30'h0, bcc_pkg::LEVEL_1V8});
    chk({30'h0, ctrl.drive}, {30'h0, bcc_pkg::DRIVE_NORM});
    chk({31'h0, cont}, 32'h1);
    chk({31'h0, swb}, 32'h0);
    @(posedge clk);
    rst_b <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h00000140);
    $display("test second reset done");
    wrap_up;
  end
endmodule
